// file: hw/uefr_regs.sv
`timescale 1ns/1ps
`include "uefr_params.svh"
// Function
// - Carrier-detect change sets delta, may interrupt
// - Loopback modem inputs mirror modem control bits
// - Scratch byte resets to all ones
// - Swap on: scratch writes hit mode register
// - Swap on: scratch reads return fill level
// - Mode bits select rx, tx or alternating count
// - Alternating mode starts rx, then toggles
// - Four-bit code selects flow hysteresis table
// - Line error interrupt delayed or immediate
// - Top mode bit selects 8x/16x, default 16x
// - Divisor is sixteen-bit integer plus fraction/16
// - Fraction register accessible only with enhanced bit
// - Fixed read-only part identifier
// - Fixed read-only revision code
// - Trigger write goes rx or tx by select
// - Extended count only under key; rx/tx select
// - Half-duplex bit steers direction and tx interrupt
// - Two bits choose trigger table
// - Enhanced bit gates changes; reset clears them
module uefr_regs (
    input  wire logic                   clk_sys,     // 40 MHz system clock
    input  wire logic                   arst_n,      // Async reset, active low
    input  wire logic                   psel,        // APB select
    input  wire logic                   penable,     // APB enable
    input  wire logic                   pwrite,      // APB direction
    input  wire logic [11:0]            paddr,       // APB byte address
    input  wire logic [31:0]            pwdata,      // APB write data
    output logic      [31:0]            prdata,      // APB read data
    output logic                        pready,      // APB ready
    output logic                        pslverr,     // APB error
    input  wire uefr_pkg::uefr_fifo_stat_t fifo_stat, // Datapath FIFO status
    input  wire logic                   rx_err_enq,  // Errored char enters FIFO
    input  wire logic                   rx_err_rhr,  // Errored char reaches RX_HOLDING_REG
    output uefr_pkg::uefr_cfg_t         cfg,         // Datapath configuration
    output logic                        modem_irq,   // Modem status interrupt
    output logic                        line_irq,    // Line error interrupt
    output logic                        tx_irq,      // Transmit interrupt
    output logic                        dir_tx_en,   // Transceiver drive direction
    output logic                        loopback     // Internal loopback active
);
    // Register storage
    logic [7:0] modem_control_reg;                  // Modem control
    logic [7:0] user_scratch_byte;                  // Scratch byte
    logic [7:0] enhanced_mode_write_reg;            // Enhanced mode
    logic [7:0] divisor_low_byte;                   // Divisor low
    logic [7:0] divisor_high_byte;                  // Divisor high
    logic [7:0] divisor_fraction;                   // Divisor fraction
    logic [7:0] feature_control;                    // Feature control
    logic [7:0] line_format_reg;                    // Line format
    logic [7:0] extended_feature_reg;               // Extended feature
    logic [7:0] irq_enable_reg;                     // Interrupt enable
    logic [7:0] rx_trig_reg;                        // User rx trigger
    logic [7:0] tx_trig_reg;                        // User tx trigger
    logic [3:0] delta_reg;                          // Modem delta flags
    logic [3:0] loop_prev_reg;                      // Last seen loopback inputs
    logic       alt_tx_reg;                         // Alternating phase
    logic       line_irq_reg;                       // Line error pending
    logic [7:0] rdata_next;                         // Read mux result
    logic       addr_ok;                            // Address mapped
    logic [3:0] loop_in;                            // Loopback modem inputs
    uefr_pkg::uefr_lvl_mode_t lvl_mode;             // Level readback mode

    // Access strobes
    wire wr_acc = psel && penable && pwrite;
    wire rd_acc = psel && penable && !pwrite;
    wire swap   = feature_control[`UEFR_FC_SWAP_BIT];
    wire enh    = extended_feature_reg[`UEFR_EF_ENH_BIT];
    wire key_on = line_format_reg == `UEFR_LF_EXT_KEY;
    wire [7:0] wbyte = pwdata[7:0];

    // Offset match helper
    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        hit = (a == o);
    endfunction : hit

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign loopback = modem_control_reg[`UEFR_MC_LOOP_BIT];

    // Loopback inputs: cts, dsr, ri, cd from control bits
    assign loop_in = {modem_control_reg[3], modem_control_reg[2],
                      modem_control_reg[0], modem_control_reg[1]};

    // Level mode decode
    always_comb begin
        if (!enhanced_mode_write_reg[0]) begin
            lvl_mode = uefr_pkg::UEFR_LVL_RX;
        end else if (!enhanced_mode_write_reg[1]) begin
            lvl_mode = uefr_pkg::UEFR_LVL_TX;
        end else begin
            lvl_mode = uefr_pkg::UEFR_LVL_ALT;
        end
    end

    // Plain registers written by software
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            modem_control_reg    <= `UEFR_RST_ZERO;
            feature_control      <= `UEFR_RST_ZERO;
            line_format_reg      <= `UEFR_RST_ZERO;
            extended_feature_reg <= `UEFR_RST_ZERO;
            irq_enable_reg       <= `UEFR_RST_ZERO;
            divisor_low_byte     <= `UEFR_RST_DIV_LOW;
            divisor_high_byte    <= `UEFR_RST_ZERO;
        end else if (wr_acc) begin
            if (hit(paddr, `UEFR_OFS_MODEM_CONTROL)) begin
                // Upper control bits are enhanced and locked when disabled
                modem_control_reg <= enh ? wbyte
                                   : {modem_control_reg[7:5], wbyte[4:0]};
            end
            if (hit(paddr, `UEFR_OFS_FEATURE_CTRL)) begin
                feature_control <= wbyte;
            end
            if (hit(paddr, `UEFR_OFS_LINE_FORMAT)) begin
                line_format_reg <= wbyte;
            end
            if (hit(paddr, `UEFR_OFS_EXT_FEATURE)) begin
                extended_feature_reg <= wbyte;
            end
            if (hit(paddr, `UEFR_OFS_IRQ_ENABLE)) begin
                irq_enable_reg <= enh ? wbyte
                                : {irq_enable_reg[7:4], wbyte[3:0]};
            end
            if (hit(paddr, `UEFR_OFS_DIV_LOW)) begin
                divisor_low_byte <= wbyte;
            end
            if (hit(paddr, `UEFR_OFS_DIV_HIGH)) begin
                divisor_high_byte <= wbyte;
            end
        end
    end

    // Fraction, only writable while enhanced enabled
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            divisor_fraction <= `UEFR_RST_ZERO;
        end else if (wr_acc && enh && hit(paddr, `UEFR_OFS_DIV_FRACTION)) begin
            divisor_fraction <= wbyte;
        end
    end

    // Scratch location: byte or enhanced mode by swap bit
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            user_scratch_byte       <= `UEFR_RST_SCRATCH;
            enhanced_mode_write_reg <= `UEFR_RST_ENH_MODE;
        end else if (wr_acc && hit(paddr, `UEFR_OFS_SCRATCH)) begin
            if (swap) begin
                enhanced_mode_write_reg <= wbyte;
            end else begin
                user_scratch_byte <= wbyte;
            end
        end
    end

    // Alternating count phase
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            alt_tx_reg <= 1'b0;
        end else if (wr_acc && swap && hit(paddr, `UEFR_OFS_SCRATCH)) begin
            alt_tx_reg <= 1'b0;
        end else if (rd_acc && swap && hit(paddr, `UEFR_OFS_SCRATCH)
                     && lvl_mode == uefr_pkg::UEFR_LVL_ALT) begin
            alt_tx_reg <= !alt_tx_reg;
        end
    end

    // User trigger levels
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rx_trig_reg <= `UEFR_RST_ZERO;
            tx_trig_reg <= `UEFR_RST_ZERO;
        end else if (wr_acc && hit(paddr, `UEFR_OFS_TRIGGER)) begin
            if (feature_control[`UEFR_FC_TRGSEL_BIT]) begin
                tx_trig_reg <= wbyte;
            end else begin
                rx_trig_reg <= wbyte;
            end
        end
    end

    // Modem delta flags; a change wins over the read clear
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            delta_reg     <= 4'h0;
            loop_prev_reg <= 4'h0;
        end else begin
            loop_prev_reg <= loop_in;
            if (rd_acc && hit(paddr, `UEFR_OFS_MODEM_STATUS)) begin
                // Keep flags set after the setup capture, so none is lost
                delta_reg <= (delta_reg & ~prdata[3:0])
                           | (loop_in ^ loop_prev_reg);
            end else begin
                delta_reg <= delta_reg | (loop_in ^ loop_prev_reg);
            end
        end
    end

    // Line error interrupt, delayed or immediate
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            line_irq_reg <= 1'b0;
        end else begin
            line_irq_reg <= enhanced_mode_write_reg[`UEFR_EM_LSRIMM_BIT]
                          ? fifo_stat.err_in_fifo || rx_err_enq
                          : fifo_stat.err_in_rhr || rx_err_rhr;
        end
    end

    // Interrupt and direction outputs
    assign modem_irq = irq_enable_reg[`UEFR_IE_MODEM_BIT] && |delta_reg;
    assign line_irq  = line_irq_reg;
    assign tx_irq    = feature_control[`UEFR_FC_HDUPLEX_BIT]
                     ? fifo_stat.thr_empty && fifo_stat.tsr_empty
                     : fifo_stat.thr_empty;
    assign dir_tx_en = feature_control[`UEFR_FC_HDUPLEX_BIT]
                     ? modem_control_reg[1] : 1'b1;

    // Configuration to datapath
    always_comb begin
        cfg.div_int       = {divisor_high_byte, divisor_low_byte};
        cfg.div_frac      = divisor_fraction[3:0];
        cfg.hysteresis    = {enhanced_mode_write_reg[5:4], feature_control[1:0]} == 4'h0
                          ? 6'd0 : hyst_lut({enhanced_mode_write_reg[5:4],
                                             feature_control[1:0]});
        cfg.sample_16x    = enhanced_mode_write_reg[`UEFR_EM_SAMPLE_BIT];
        cfg.lsr_immediate = enhanced_mode_write_reg[`UEFR_EM_LSRIMM_BIT];
        cfg.half_duplex   = feature_control[`UEFR_FC_HDUPLEX_BIT];
        cfg.trig_table    = uefr_pkg::uefr_table_t'(feature_control[5:4]);
        cfg.rx_trigger    = rx_trig_reg;
        cfg.tx_trigger    = tx_trig_reg;
    end

    // Hysteresis table in characters
    function automatic logic [5:0] hyst_lut(input logic [3:0] code);
        unique case (code)
            4'h0: hyst_lut = 6'd0;
            4'h1: hyst_lut = 6'd4;
            4'h2: hyst_lut = 6'd6;
            4'h3: hyst_lut = 6'd8;
            4'h4: hyst_lut = 6'd8;
            4'h5: hyst_lut = 6'd16;
            4'h6: hyst_lut = 6'd24;
            4'h7: hyst_lut = 6'd32;
            4'h8: hyst_lut = 6'd40;
            4'h9: hyst_lut = 6'd44;
            4'hA: hyst_lut = 6'd48;
            4'hB: hyst_lut = 6'd52;
            4'hC: hyst_lut = 6'd12;
            4'hD: hyst_lut = 6'd20;
            4'hE: hyst_lut = 6'd28;
            4'hF: hyst_lut = 6'd36;
        endcase
    endfunction : hyst_lut

    // Read mux
    always_comb begin
        rdata_next = 8'h00;
        addr_ok    = 1'b1;
        unique case (paddr)
            `UEFR_OFS_MODEM_STATUS:  rdata_next = {loop_in, delta_reg};
            `UEFR_OFS_MODEM_CONTROL: rdata_next = modem_control_reg;
            `UEFR_OFS_SCRATCH: begin
                if (!swap) begin
                    rdata_next = user_scratch_byte;
                end else if (lvl_mode == uefr_pkg::UEFR_LVL_TX
                          || (lvl_mode == uefr_pkg::UEFR_LVL_ALT && alt_tx_reg)) begin
                    rdata_next = fifo_stat.tx_count;
                end else begin
                    rdata_next = fifo_stat.rx_count;
                end
            end
            `UEFR_OFS_DIV_LOW:       rdata_next = divisor_low_byte;
            `UEFR_OFS_DIV_HIGH:      rdata_next = divisor_high_byte;
            `UEFR_OFS_DIV_FRACTION:  rdata_next = enh ? divisor_fraction : 8'h00;
            `UEFR_OFS_PART_ID:       rdata_next = `UEFR_PART_ID_VAL;
            `UEFR_OFS_PART_REV:      rdata_next = `UEFR_PART_REV_VAL;
            `UEFR_OFS_TRIGGER:       rdata_next = 8'h00;
            `UEFR_OFS_FIFO_COUNT: begin
                if (key_on) begin
                    rdata_next = feature_control[`UEFR_FC_TRGSEL_BIT]
                               ? fifo_stat.tx_count : fifo_stat.rx_count;
                end
            end
            `UEFR_OFS_FEATURE_CTRL:  rdata_next = feature_control;
            `UEFR_OFS_LINE_FORMAT:   rdata_next = line_format_reg;
            `UEFR_OFS_EXT_FEATURE:   rdata_next = extended_feature_reg;
            `UEFR_OFS_IRQ_ENABLE:    rdata_next = irq_enable_reg;
            `UEFR_OFS_STATUS:        rdata_next = {5'h00, line_irq_reg, modem_irq, tx_irq};
            default:                 addr_ok = 1'b0;
        endcase
    end

    // Read data register, updated in setup phase
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata <= {24'h00_0000, rdata_next};
        end
    end
endmodule : uefr_regs

// file: hw/uefr_params.svh
`ifndef UEFR_PARAMS_SVH
`define UEFR_PARAMS_SVH
// Register byte offsets on the APB window
`define UEFR_OFS_MODEM_STATUS   12'h000
`define UEFR_OFS_MODEM_CONTROL  12'h004
`define UEFR_OFS_SCRATCH        12'h008
`define UEFR_OFS_DIV_LOW        12'h00C
`define UEFR_OFS_DIV_HIGH       12'h010
`define UEFR_OFS_DIV_FRACTION   12'h014
`define UEFR_OFS_PART_ID        12'h018
`define UEFR_OFS_PART_REV       12'h01C
`define UEFR_OFS_TRIGGER        12'h020
`define UEFR_OFS_FIFO_COUNT     12'h024
`define UEFR_OFS_FEATURE_CTRL   12'h028
`define UEFR_OFS_LINE_FORMAT    12'h02C
`define UEFR_OFS_EXT_FEATURE    12'h030
`define UEFR_OFS_IRQ_ENABLE     12'h034
`define UEFR_OFS_STATUS         12'h038
// Reset values
`define UEFR_RST_SCRATCH        8'hFF
`define UEFR_RST_ENH_MODE       8'h80
`define UEFR_RST_DIV_LOW        8'h01
`define UEFR_RST_ZERO           8'h00
// Identity codes, arbitrary values
`define UEFR_PART_ID_VAL        8'h5C
`define UEFR_PART_REV_VAL       8'h07
// Special line format value unlocking the extended count register
`define UEFR_LF_EXT_KEY         8'hBF
// Field positions
`define UEFR_FC_SWAP_BIT        6
`define UEFR_FC_TRGSEL_BIT      7
`define UEFR_FC_HDUPLEX_BIT     3
`define UEFR_EF_ENH_BIT         4
`define UEFR_MC_LOOP_BIT        4
`define UEFR_IE_MODEM_BIT       3
`define UEFR_EM_LSRIMM_BIT      6
`define UEFR_EM_SAMPLE_BIT      7
`endif

// file: hw/uefr_pkg.sv
package uefr_pkg;
    // Level readback selection
    typedef enum logic [2:0] {
        UEFR_LVL_RX  = 3'b001,
        UEFR_LVL_TX  = 3'b010,
        UEFR_LVL_ALT = 3'b100
    } uefr_lvl_mode_t;
    // Trigger table choice
    typedef enum logic [1:0] {
        UEFR_TBL_A = 2'b00,
        UEFR_TBL_B = 2'b01,
        UEFR_TBL_C = 2'b10,
        UEFR_TBL_D = 2'b11
    } uefr_table_t;
    // FIFO side status from the datapath
    typedef struct packed {
        logic [7:0] rx_count;
        logic [7:0] tx_count;
        logic       thr_empty;
        logic       tsr_empty;
        logic       err_in_fifo;
        logic       err_in_rhr;
    } uefr_fifo_stat_t;
    // Configuration handed to the datapath
    typedef struct packed {
        logic [15:0] div_int;
        logic [3:0]  div_frac;
        logic [5:0]  hysteresis;
        logic        sample_16x;
        logic        lsr_immediate;
        logic        half_duplex;
        uefr_table_t trig_table;
        logic [7:0]  rx_trigger;
        logic [7:0]  tx_trigger;
    } uefr_cfg_t;
endpackage : uefr_pkg

// file: testbench/uefr_fifo_model.sv
`timescale 1ns/1ps
// Datapath stand-in: FIFO levels, shifter state, errored characters
module uefr_fifo_model (
    input  wire logic                      clk_sys,    // System clock
    input  wire logic                      arst_n,     // Async reset, active low
    input  wire logic [7:0]                rx_lvl,     // Receive level to show
    input  wire logic [7:0]                tx_lvl,     // Transmit level to show
    input  wire logic                      tsr_busy,   // Shifter still sending
    input  wire logic                      err_go,     // Launch one errored char
    output uefr_pkg::uefr_fifo_stat_t      fifo_stat,  // Status to the block
    output logic                           rx_err_enq, // Errored char enters FIFO
    output logic                           rx_err_rhr  // Errored char reaches head
);
    logic [3:0] err_pipe_reg; // Errored char walking to the holding stage

    // Char enters the FIFO first, reaches the head three cycles later
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            err_pipe_reg <= 4'h0;
        end else begin
            err_pipe_reg <= {err_pipe_reg[2:0], err_go};
        end
    end
    assign rx_err_enq            = err_pipe_reg[0];
    assign rx_err_rhr            = err_pipe_reg[3];
    assign fifo_stat.rx_count    = rx_lvl;
    assign fifo_stat.tx_count    = tx_lvl;
    assign fifo_stat.thr_empty   = (tx_lvl == 8'h00);
    assign fifo_stat.tsr_empty   = !tsr_busy;
    assign fifo_stat.err_in_fifo = |err_pipe_reg[2:0];
    assign fifo_stat.err_in_rhr  = err_pipe_reg[3];
endmodule : uefr_fifo_model

// file: testbench/uefr_checker.sv
`timescale 1ns/1ps
`include "uefr_params.svh"
// Port-level checks of the enhanced register block
module uefr_checker (
    input wire logic                      clk_sys,    // System clock
    input wire logic                      arst_n,     // Async reset, active low
    input wire logic                      psel,       // APB select
    input wire logic                      penable,    // APB enable
    input wire logic                      pwrite,     // APB direction
    input wire logic [11:0]               paddr,      // APB address
    input wire logic [31:0]               prdata,     // APB read data
    input wire uefr_pkg::uefr_fifo_stat_t fifo_stat,  // Datapath status
    input wire logic                      rx_err_enq, // Error entered FIFO
    input wire logic                      rx_err_rhr, // Error reached head
    input wire uefr_pkg::uefr_cfg_t       cfg,        // Configuration out
    input wire logic                      modem_irq,  // Modem interrupt
    input wire logic                      line_irq,   // Line interrupt
    input wire logic                      tx_irq,     // Transmit interrupt
    input wire logic                      dir_tx_en   // Drive direction
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    logic wr; // Write landing this edge
    logic rd; // Read answered this edge
    logic line_src; // Error event that may raise the line interrupt
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign line_src = cfg.lsr_immediate ? rx_err_enq : rx_err_rhr;

    a_id_fixed: assert property (rd && paddr == `UEFR_OFS_PART_ID
        |-> prdata == {24'h00_0000, `UEFR_PART_ID_VAL}) else $error("part id wrong");
    a_rev_fixed: assert property (rd && paddr == `UEFR_OFS_PART_REV
        |-> prdata == {24'h00_0000, `UEFR_PART_REV_VAL}) else $error("revision wrong");
    a_trig_unread: assert property (rd && paddr == `UEFR_OFS_TRIGGER
        |-> prdata == 32'h0000_0000) else $error("trigger readable");
    a_full_dir: assert property (!cfg.half_duplex |-> dir_tx_en)
        else $error("full duplex not driving");
    a_half_txwait: assert property (cfg.half_duplex && !fifo_stat.tsr_empty
        |-> !tx_irq) else $error("tx irq before shifter empty");
    a_line_cause: assert property ($rose(line_irq) |-> $past(line_src))
        else $error("line irq from wrong event");
    a_modem_cause: assert property ($rose(modem_irq) |-> $past(wr) || $past(wr, 2))
        else $error("modem irq without write");
    a_delta_clear: assert property (rd && paddr == `UEFR_OFS_MODEM_STATUS
        |=> !modem_irq) else $error("delta not cleared");
    a_frac_hold: assert property (!(wr && paddr == `UEFR_OFS_DIV_FRACTION)
        |=> $stable(cfg.div_frac)) else $error("fraction changed");
    a_mode_src: assert property ($changed(cfg.sample_16x)
        |-> $past(wr) && $past(paddr) == `UEFR_OFS_SCRATCH) else $error("mode source");
endmodule : uefr_checker

bind uefr_regs uefr_checker u_chk (.clk_sys, .arst_n, .psel, .penable, .pwrite, .paddr,
    .prdata, .fifo_stat, .rx_err_enq, .rx_err_rhr, .cfg, .modem_irq, .line_irq,
    .tx_irq, .dir_tx_en);

// file: testbench/testbench.sv
`timescale 1ns/1ps
`include "uefr_params.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module testbench;
    logic clk_sys = 1'b0; // 40 MHz clock
    logic arst_n = 1'b0; // Reset, active low
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB controls
    logic [11:0] paddr = 12'h000; // APB address
    logic [31:0] pwdata = 32'h0000_0000, prdata; // APB data
    logic pready, pslverr, modem_irq, line_irq, tx_irq, dir_tx_en, loopback;
    logic rx_err_enq, rx_err_rhr, tsr_busy = 1'b0, err_go = 1'b0;
    logic [7:0] rx_lvl = 8'h00, tx_lvl = 8'h00, d8, h8, f8; // Levels and data
    uefr_pkg::uefr_fifo_stat_t fifo_stat; // Datapath status
    uefr_pkg::uefr_cfg_t cfg; // Configuration out
    logic [32:0] exp_q[$]; // Expected {error, read data}
    logic [32:0] e; // Oldest expectation
    int num_errors = 0, n_compared = 0, seed = 32'h8d90;
    int hyst[16] = '{0, 4, 6, 8, 8, 16, 24, 32, 40, 44, 48, 52, 12, 20, 28, 36};

    always #12.5 clk_sys = ~clk_sys;
    uefr_regs uut (.clk_sys, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .fifo_stat, .rx_err_enq, .rx_err_rhr, .cfg,
        .modem_irq, .line_irq, .tx_irq, .dir_tx_en, .loopback);
    uefr_fifo_model u_model (.clk_sys, .arst_n, .rx_lvl, .tx_lvl, .tsr_busy, .err_go,
        .fifo_stat, .rx_err_enq, .rx_err_rhr);

    // Compares each answered read with the oldest expectation
    always @(posedge clk_sys) begin
        if (psel && penable && pready && !pwrite) begin
            e = exp_q.pop_front();
            `CHK("prdata", e[31:0], prdata)
            `CHK("pslverr", e[32], pslverr)
        end
    end

    task give_verdict();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : give_verdict

    // One APB transfer, then an idle cycle
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k == 20) begin
            num_errors++;
            give_verdict();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb

    task wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h00_0000, d});
    endtask : wr

    task rd(input logic [11:0] a, input logic [7:0] x);
        exp_q.push_back({9'h000, 16'h0000, x});
        apb(1'b0, a, 32'h0000_0000);
    endtask : rd

    task do_reset();
        arst_n <= 1'b0;
        repeat (16) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
    endtask : do_reset

    // Main sequence
    initial begin
        do_reset();
        rd(`UEFR_OFS_SCRATCH, 8'hFF);
        rd(`UEFR_OFS_DIV_FRACTION, 8'h00);
        `CHK("sample_16x", 1'b1, cfg.sample_16x)
        `CHK("div_int", 16'h0001, cfg.div_int)
        d8 = $random(seed);
        wr(`UEFR_OFS_SCRATCH, d8);
        rd(`UEFR_OFS_SCRATCH, d8);
        rx_lvl <= $random(seed);
        tx_lvl <= $random(seed);
        wr(`UEFR_OFS_FEATURE_CTRL, 8'h40);
        wr(`UEFR_OFS_SCRATCH, 8'h00);
        rd(`UEFR_OFS_SCRATCH, rx_lvl);
        `CHK("sample_8x", 1'b0, cfg.sample_16x)
        wr(`UEFR_OFS_SCRATCH, 8'h41);
        rd(`UEFR_OFS_SCRATCH, tx_lvl);
        `CHK("lsr_imm", 1'b1, cfg.lsr_immediate)
        for (int i = 0; i < 2; i++) begin
            wr(`UEFR_OFS_SCRATCH, 8'h03);
            rd(`UEFR_OFS_SCRATCH, rx_lvl);
            rd(`UEFR_OFS_SCRATCH, tx_lvl);
            rd(`UEFR_OFS_SCRATCH, rx_lvl);
        end
        wr(`UEFR_OFS_FEATURE_CTRL, 8'h00);
        rd(`UEFR_OFS_SCRATCH, d8);
        $display("test scratch swap done");
        for (int c = 0; c < 16; c++) begin
            wr(`UEFR_OFS_FEATURE_CTRL, 8'h40 + c[1:0]);
            wr(`UEFR_OFS_SCRATCH, {2'b10, c[3:2], 4'h0});
            `CHK("hysteresis", 6'(hyst[c]), cfg.hysteresis)
        end
        for (int t = 0; t < 4; t++) begin
            wr(`UEFR_OFS_FEATURE_CTRL, {2'b00, t[1:0], 4'h0});
            `CHK("table", t[1:0], cfg.trig_table)
        end
        h8 = $random(seed);
        wr(`UEFR_OFS_FEATURE_CTRL, 8'hB0);
        wr(`UEFR_OFS_TRIGGER, h8);
        `CHK("tx_trigger", h8, cfg.tx_trigger)
        wr(`UEFR_OFS_FEATURE_CTRL, 8'h30);
        wr(`UEFR_OFS_TRIGGER, d8);
        `CHK("rx_trigger", d8, cfg.rx_trigger)
        `CHK("tx_kept", h8, cfg.tx_trigger)
        rd(`UEFR_OFS_TRIGGER, 8'h00);
        $display("test tables done");
        wr(`UEFR_OFS_DIV_FRACTION, 8'h09);
        rd(`UEFR_OFS_DIV_FRACTION, 8'h00);
        wr(`UEFR_OFS_EXT_FEATURE, 8'h10);
        f8 = ($random(seed) & 32'h0000_0007) | 32'h0000_0008;
        wr(`UEFR_OFS_DIV_FRACTION, f8);
        rd(`UEFR_OFS_DIV_FRACTION, f8);
        wr(`UEFR_OFS_DIV_LOW, d8);
        wr(`UEFR_OFS_DIV_HIGH, h8);
        `CHK("div_int", {h8, d8}, cfg.div_int)
        `CHK("div_frac", f8[3:0], cfg.div_frac)
        wr(`UEFR_OFS_EXT_FEATURE, 8'h00);
        wr(`UEFR_OFS_DIV_FRACTION, ~f8);
        `CHK("frac_kept", f8[3:0], cfg.div_frac)
        wr(`UEFR_OFS_DIV_LOW, 8'h00);
        wr(`UEFR_OFS_DIV_HIGH, 8'h00);
        rd(`UEFR_OFS_PART_ID, `UEFR_PART_ID_VAL);
        rd(`UEFR_OFS_PART_REV, `UEFR_PART_REV_VAL);
        rd(`UEFR_OFS_FIFO_COUNT, 8'h00);
        wr(`UEFR_OFS_LINE_FORMAT, `UEFR_LF_EXT_KEY);
        wr(`UEFR_OFS_FEATURE_CTRL, 8'h00);
        rd(`UEFR_OFS_FIFO_COUNT, rx_lvl);
        wr(`UEFR_OFS_FEATURE_CTRL, 8'h80);
        rd(`UEFR_OFS_FIFO_COUNT, tx_lvl);
        wr(`UEFR_OFS_LINE_FORMAT, 8'h00);
        $display("test divisor id count done");
        wr(`UEFR_OFS_IRQ_ENABLE, 8'h0F);
        wr(`UEFR_OFS_MODEM_CONTROL, 8'h10);
        rd(`UEFR_OFS_MODEM_STATUS, 8'h00);
        wr(`UEFR_OFS_MODEM_CONTROL, 8'h18);
        @(posedge clk_sys);
        `CHK("modem_irq", 1'b1, modem_irq)
        rd(`UEFR_OFS_MODEM_STATUS, 8'h88);
        `CHK("modem_irq", 1'b0, modem_irq)
        rd(`UEFR_OFS_MODEM_STATUS, 8'h80);
        wr(`UEFR_OFS_MODEM_CONTROL, 8'h17);
        rd(`UEFR_OFS_MODEM_STATUS, 8'h7F);
        `CHK("loopback", 1'b1, loopback)
        tsr_busy <= 1'b1;
        tx_lvl <= 8'h00;
        wr(`UEFR_OFS_FEATURE_CTRL, 8'h00);
        `CHK("tx_irq_full", 1'b1, tx_irq)
        wr(`UEFR_OFS_FEATURE_CTRL, 8'h08);
        `CHK("tx_irq_half", 1'b0, tx_irq)
        `CHK("dir_rts", 1'b1, dir_tx_en)
        wr(`UEFR_OFS_MODEM_CONTROL, 8'h00);
        `CHK("dir_idle", 1'b0, dir_tx_en)
        tsr_busy <= 1'b0;
        repeat (2) @(posedge clk_sys);
        `CHK("tx_irq_done", 1'b1, tx_irq)
        wr(`UEFR_OFS_FEATURE_CTRL, 8'h40);
        for (int m = 0; m < 2; m++) begin
            wr(`UEFR_OFS_SCRATCH, {!m[0], m[0], 6'h00});
            err_go <= 1'b1;
            @(posedge clk_sys);
            err_go <= 1'b0;
            repeat (2) @(posedge clk_sys);
            `CHK("line_wait", m[0], line_irq)
            repeat (3) @(posedge clk_sys);
            `CHK("line_irq", !m[0], line_irq)
        end
        exp_q.push_back({1'b1, 32'h0000_0000});
        apb(1'b0, 12'h03C, 32'h0000_0000);
        $display("test modem duplex line done");
        do_reset();
        rd(`UEFR_OFS_DIV_FRACTION, 8'h00);
        `CHK("frac_rst", 4'h0, cfg.div_frac)
        `CHK("sample_16x", 1'b1, cfg.sample_16x)
        $display("test second reset done");
        give_verdict();
    end
endmodule : testbench
